/* rtl/ias_pkg.sv */
package ias_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int PTR_COUNT_DEF = 3;
	localparam int MEM_DEPTH_DEF = 4096;
	// data-space map of this block's special locations
	localparam logic [ADDR_W-1:0] OPERAND_BASE = 12'hf00;
	localparam logic [ADDR_W-1:0] OPERAND_STRIDE = 12'h008;
	localparam logic [ADDR_W-1:0] PTR_BASE = 12'hf20;
	localparam logic [ADDR_W-1:0] FLAGS_ADDR = 12'hf30;
	localparam logic [ADDR_W-1:0] PTR_STEP = 12'h001;
	// flag register layout
	localparam int FLAG_C = 0;
	localparam int FLAG_NC = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_N = 4;
	localparam logic [DATA_W-1:0] FLAGS_IMPL_MASK = 8'h1f;
	localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
	localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
	localparam logic [4:0] MASK_ALL = 5'h1f;
	localparam logic [4:0] MASK_LOGIC = 5'h14;
	localparam logic [4:0] MASK_ROTATE = 5'h17;
	localparam logic [2:0] MODE_LIMIT = 3'h4;

	typedef enum logic [2:0] {
		mode_plain,
		mode_post_down,
		mode_post_up,
		mode_pre_up,
		mode_acc_offset
	} port_mode_t;

	typedef enum logic [2:0] {
		alu_add,
		alu_sub,
		alu_and,
		alu_or,
		alu_xor,
		alu_rot_left,
		alu_rot_right
	} alu_op_t;
endpackage : ias_pkg

/* rtl/alu_flag_unit.sv */
`timescale 1ns/1ps
module alu_flag_unit import ias_pkg::*; (
	// operation
	input wire alu_op_t op,
	input wire logic [DATA_W-1:0] a,
	input wire logic [DATA_W-1:0] b,
	input wire logic carry_in,
	// outcome
	output logic [DATA_W-1:0] result,
	output logic [4:0] flags,
	output logic [4:0] mask
);
	logic [DATA_W:0] sum;
	logic [4:0] low_sum;
	logic [DATA_W-1:0] b_eff;

	always_comb begin
		b_eff = (op == alu_sub) ? ~b : b;
		sum = {1'b0, a} + {1'b0, b_eff} + {8'h00, op == alu_sub};
		low_sum = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, op == alu_sub};
		flags = 5'h00;
		mask = MASK_ALL;
		result = sum[DATA_W-1:0];
		unique case (op)
			alu_add, alu_sub: begin
				flags[FLAG_C] = sum[DATA_W];
				flags[FLAG_NC] = low_sum[4];
				flags[FLAG_OV] = (a[7] == b_eff[7]) && (result[7] != a[7]);
			end
			alu_and: begin
				result = a & b;
				mask = MASK_LOGIC;
			end
			alu_or: begin
				result = a | b;
				mask = MASK_LOGIC;
			end
			alu_xor: begin
				result = a ^ b;
				mask = MASK_LOGIC;
			end
			alu_rot_left: begin
				result = {a[6:0], carry_in};
				flags[FLAG_C] = a[7];
				flags[FLAG_NC] = a[3];
				mask = MASK_ROTATE;
			end
			alu_rot_right: begin
				result = {carry_in, a[7:1]};
				flags[FLAG_C] = a[0];
				flags[FLAG_NC] = a[4];
				mask = MASK_ROTATE;
			end
			// the spare operation code gives the add result but clears C, NC and OV
			default: result = sum[DATA_W-1:0];
		endcase
		flags[FLAG_N] = result[7];
		flags[FLAG_Z] = (result == DATA_ZERO);
	end
endmodule : alu_flag_unit

/* rtl/data_store.sv */
`timescale 1ns/1ps
module data_store import ias_pkg::*; #(
	parameter int DEPTH = MEM_DEPTH_DEF
) (
	// clock
	input wire logic core_clk,
	// access
	input wire logic [ADDR_W-1:0] addr,
	input wire logic we,
	input wire logic [DATA_W-1:0] wdata,
	output logic [DATA_W-1:0] rdata
);
	localparam int IW = $clog2(DEPTH);

	logic [DATA_W-1:0] mem [DEPTH];
	logic [IW-1:0] index;

	generate
		if (DEPTH < 2 || DEPTH > MEM_DEPTH_DEF || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("data_store depth must be a power of two up to the data space");
		end
	endgenerate

	// a smaller store aliases over the data space
	assign index = addr[IW-1:0];
	assign rdata = mem[index];

	always_ff @(posedge core_clk) begin
		if (we) begin
			mem[index] <= wdata;
		end
	end
endmodule : data_store

/* rtl/indirect_addr_status_flags.sv */
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module indirect_addr_status_flags import ias_pkg::*; #(
	parameter int PTR_COUNT = PTR_COUNT_DEF,
	parameter int MEM_DEPTH = MEM_DEPTH_DEF
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// core data port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DATA_W-1:0] rdata,
	// accumulator used by the offset ports
	input wire logic [DATA_W-1:0] working_accumulator,
	// alu flag request
	input wire logic alu_valid,
	input wire alu_op_t alu_op,
	input wire logic [DATA_W-1:0] alu_a,
	input wire logic [DATA_W-1:0] alu_b,
	output logic [DATA_W-1:0] alu_result,
	// flag register
	output logic [DATA_W-1:0] alu_flags
);
	localparam int PW = $clog2(PTR_COUNT);

	generate
		if (PTR_COUNT < 2 || PTR_COUNT > 4) begin : g_bad_count
			$error("pointer count must lie between 2 and 4");
		end
	endgenerate

	// operand port decode: one stride of addresses per pointer, five used
	function automatic logic port_hit(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] off;
		off = a - OPERAND_BASE;
		return (a >= OPERAND_BASE) && (off[ADDR_W-1:3] < PTR_COUNT) && (a[2:0] <= MODE_LIMIT);
	endfunction : port_hit

	function automatic logic [PW-1:0] port_ptr(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] off;
		off = a - OPERAND_BASE;
		return off[PW+2:3];
	endfunction : port_ptr

	// pointer byte decode: lower byte at even, upper byte at odd address
	function automatic logic byte_hit(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] off;
		off = a - PTR_BASE;
		return (a >= PTR_BASE) && (off[ADDR_W-1:1] < PTR_COUNT);
	endfunction : byte_hit

	function automatic logic [PW-1:0] byte_ptr(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] off;
		off = a - PTR_BASE;
		return off[PW:1];
	endfunction : byte_ptr

	// sums are cut to the data space, so steps and offsets wrap
	function automatic logic [ADDR_W-1:0] wrap_add(input logic [ADDR_W-1:0] x, input logic [ADDR_W-1:0] y);
		logic [ADDR_W:0] s;
		s = {1'b0, x} + {1'b0, y};
		return s[ADDR_W-1:0];
	endfunction : wrap_add

	logic [ADDR_W-1:0] indirect_pointer [PTR_COUNT];
	logic hit;
	logic [PW-1:0] sel;
	port_mode_t mode;
	logic [ADDR_W-1:0] base;
	logic [ADDR_W-1:0] target;
	logic [ADDR_W-1:0] next_pointer;
	logic [ADDR_W-1:0] eff;
	logic nested;
	logic access;
	logic do_wr;
	logic eff_byte;
	logic [PW-1:0] eff_ptr;
	logic eff_flags;
	logic mem_we;
	logic [DATA_W-1:0] mem_rdata;
	logic [DATA_W-1:0] pointer_byte;
	logic [DATA_W-1:0] next_rdata;
	logic [DATA_W-1:0] next_flags;
	logic [DATA_W-1:0] calc_result;
	logic [4:0] calc_flags;
	logic [4:0] calc_mask;

	// address generation for the five operand ports
	always_comb begin
		hit = port_hit(addr);
		sel = port_ptr(addr);
		mode = port_mode_t'(addr[2:0]);
		base = indirect_pointer[sel];
		target = base;
		next_pointer = base;
		unique case (mode)
			mode_plain: target = base;
			mode_post_down: next_pointer = wrap_add(base, -PTR_STEP);
			mode_post_up: next_pointer = wrap_add(base, PTR_STEP);
			mode_pre_up: begin
				target = wrap_add(base, PTR_STEP);
				next_pointer = target;
			end
			mode_acc_offset: target = wrap_add(base, {{4{working_accumulator[7]}}, working_accumulator});
			// codes 5 to 7 belong to plain memory, not to a port
			default: target = base;
		endcase
		eff = hit ? target : addr;
		nested = hit && port_hit(target);
		access = rd || wr;
		do_wr = wr && !nested;
		eff_byte = byte_hit(eff);
		eff_ptr = byte_ptr(eff);
		eff_flags = (eff == FLAGS_ADDR);
		mem_we = do_wr && !eff_byte && !eff_flags;
	end

	data_store #(
		.DEPTH(MEM_DEPTH)
	) u_store (
		.core_clk(core_clk),
		.addr(eff),
		.we(mem_we),
		.wdata(wdata),
		.rdata(mem_rdata)
	);

	alu_flag_unit u_flags (
		.op(alu_op),
		.a(alu_a),
		.b(alu_b),
		.carry_in(alu_flags[FLAG_C]),
		.result(calc_result),
		.flags(calc_flags),
		.mask(calc_mask)
	);

	// pointer registers: a byte write through the data port beats the step
	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int i = 0; i < PTR_COUNT; i++) begin
				indirect_pointer[i] <= PTR_RESET;
			end
		end else begin
			for (int i = 0; i < PTR_COUNT; i++) begin
				if (do_wr && eff_byte && eff_ptr == PW'(i)) begin
					if (eff[0]) begin
						indirect_pointer[i][ADDR_W-1:DATA_W] <= wdata[ADDR_W-DATA_W-1:0];
					end else begin
						indirect_pointer[i][DATA_W-1:0] <= wdata;
					end
				end else if (access && hit && sel == PW'(i)) begin
					indirect_pointer[i] <= next_pointer;
				end
			end
		end
	end

	// read data
	always_comb begin
		pointer_byte = eff[0] ? {4'h0, indirect_pointer[eff_ptr][ADDR_W-1:DATA_W]} :
			indirect_pointer[eff_ptr][DATA_W-1:0];
		if (nested) begin
			next_rdata = DATA_ZERO;
		end else if (eff_byte) begin
			next_rdata = pointer_byte;
		end else if (eff_flags) begin
			next_rdata = alu_flags & FLAGS_IMPL_MASK;
		end else begin
			next_rdata = mem_rdata;
		end
	end

	// read data stand only in the cycle after the read
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata <= DATA_ZERO;
		end else if (rd) begin
			rdata <= next_rdata;
		end else begin
			rdata <= DATA_ZERO;
		end
	end

	// flag register: pointer steps never reach it
	always_comb begin
		next_flags = alu_flags;
		if (do_wr && eff_flags && !alu_valid) begin
			next_flags = wdata;
		end
		if (alu_valid && !(wr && nested)) begin
			next_flags[4:0] = (alu_flags[4:0] & ~calc_mask) | (calc_flags & calc_mask);
		end
		if (rd && nested) begin
			next_flags[FLAG_Z] = 1'b1;
		end
		next_flags = next_flags & FLAGS_IMPL_MASK;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			alu_flags <= FLAGS_RESET;
		end else begin
			alu_flags <= next_flags;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			alu_result <= DATA_ZERO;
		end else if (alu_valid) begin
			alu_result <= calc_result;
		end
	end
endmodule : indirect_addr_status_flags

/* tb/ias_checker_sva.sv */
`timescale 1ns/1ps
module ias_checker import ias_pkg::*; #(
	parameter int PTR_COUNT = PTR_COUNT_DEF,
	parameter int MEM_DEPTH = MEM_DEPTH_DEF
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// core data port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic [DATA_W-1:0] working_accumulator,
	// alu
	input wire logic alu_valid,
	input wire alu_op_t alu_op,
	input wire logic [DATA_W-1:0] alu_a,
	input wire logic [DATA_W-1:0] alu_b,
	input wire logic [DATA_W-1:0] alu_result,
	input wire logic [DATA_W-1:0] alu_flags
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);

	upper_bits_zero_a: assert property (alu_flags[7:5] == 3'h0) else $error("flag bits 7:5 set");
	rdata_idle_a: assert property (!rd |=> rdata == 8'h00) else $error("rdata without read");
	neg_flag_a: assert property (alu_valid && !wr |=> alu_flags[FLAG_N] == alu_result[7])
		else $error("negative flag wrong");
	zero_flag_a: assert property (alu_valid && !wr && !rd |=> alu_flags[FLAG_Z] == (alu_result == 8'h00))
		else $error("zero flag wrong");
	add_carry_a: assert property (alu_valid && !wr && alu_op == alu_add |=>
		alu_flags[FLAG_C] == ({1'b0, $past(alu_a)} + {1'b0, $past(alu_b)} > 9'h0ff)) else $error("carry wrong");
	add_ovf_a: assert property (alu_valid && !wr && alu_op == alu_add |=> alu_flags[FLAG_OV] ==
		($past(alu_a[7]) == $past(alu_b[7]) && alu_result[7] != $past(alu_a[7]))) else $error("overflow wrong");
	logic_keep_a: assert property (alu_valid && !wr && alu_op inside {alu_and, alu_or, alu_xor} |=>
		$stable(alu_flags[FLAG_OV]) && $stable(alu_flags[FLAG_NC:FLAG_C])) else $error("logic op touched carry flags");
	flags_write_a: assert property (wr && !alu_valid && addr == FLAGS_ADDR |=>
		alu_flags == ($past(wdata) & FLAGS_IMPL_MASK)) else $error("flag write wrong");
endmodule : ias_checker

bind indirect_addr_status_flags ias_checker #(.PTR_COUNT(PTR_COUNT), .MEM_DEPTH(MEM_DEPTH)) ias_checker_i (
	.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.working_accumulator(working_accumulator), .alu_valid(alu_valid), .alu_op(alu_op), .alu_a(alu_a),
	.alu_b(alu_b), .alu_result(alu_result), .alu_flags(alu_flags)
);

/* tb/core_model.sv */
`timescale 1ns/1ps
module core_model import ias_pkg::*; (
	// clock
	input wire logic core_clk,
	// data port
	output logic [ADDR_W-1:0] addr,
	output logic [DATA_W-1:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [DATA_W-1:0] rdata,
	// alu request
	output logic alu_valid,
	output alu_op_t alu_op,
	output logic [DATA_W-1:0] alu_a,
	output logic [DATA_W-1:0] alu_b
);
	logic [DATA_W-1:0] seen;
	initial begin
		addr = 12'h000;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		alu_valid = 1'b0;
		alu_op = alu_add;
		alu_a = 8'h00;
		alu_b = 8'h00;
	end
	task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask : put
	// read data stands only in the cycle after the strobe
	task automatic get(input logic [ADDR_W-1:0] a);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1 seen = rdata;
	endtask : get
	// w also strobes all ones at the flag register in the same cycle, but the alu update wins and the write is dropped
	task automatic alu(input alu_op_t op, input logic [DATA_W-1:0] x, input logic [DATA_W-1:0] y, input logic w);
		@(posedge core_clk);
		alu_valid <= 1'b1;
		alu_op <= op;
		alu_a <= x;
		alu_b <= y;
		addr <= FLAGS_ADDR;
		wdata <= 8'hff;
		wr <= w;
		@(posedge core_clk);
		alu_valid <= 1'b0;
		wr <= 1'b0;
		#1;
	endtask : alu
endmodule : core_model

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench import ias_pkg::*; ();
	logic core_clk;
	logic rst;
	logic wr, rd, alu_valid;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, acc, alu_a, alu_b, alu_result, alu_flags;
	alu_op_t alu_op;
	int miscompares = 0;
	int compares = 0;
	alu_op_t ops [9] = '{alu_add, alu_and, alu_or, alu_xor, alu_sub, alu_rot_left, alu_rot_right, alu_sub, alu_add};
	logic [7:0] va [9] = '{8'h7f, 8'hf0, 8'h80, 8'hff, 8'h05, 8'h88, 8'h11, 8'h00, 8'h80};
	logic [7:0] vb [9] = '{8'h01, 8'h0f, 8'h01, 8'hff, 8'h05, 8'h00, 8'h00, 8'h01, 8'h80};
	logic [7:0] vr [9] = '{8'h80, 8'h00, 8'h81, 8'h00, 8'h00, 8'h11, 8'h88, 8'hff, 8'h00};
	logic [7:0] vf [9] = '{8'h1a, 8'h0e, 8'h1a, 8'h0e, 8'h07, 8'h03, 8'h13, 8'h10, 8'h0d};

	core_model core_model_i (.core_clk(core_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.alu_valid(alu_valid), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b));
	indirect_addr_status_flags indirect_addr_status_flags_i (.core_clk(core_clk), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .working_accumulator(acc), .alu_valid(alu_valid),
		.alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b), .alu_result(alu_result), .alu_flags(alu_flags));

	task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		core_model_i.put(a, d);
	endtask : put
	task automatic peek(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		core_model_i.get(a);
		chk("rdata", e, core_model_i.seen);
	endtask : peek
	task automatic tally_and_finish();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	initial begin
		rst = 1'b1;
		acc = 8'h00;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		#1 chk("flags", FLAGS_RESET, alu_flags);
		chk("result", 8'h00, alu_result);
		// pointer 0 at 0x0ff walks all five ports across the byte boundary
		put(12'hf20, 8'hff);
		put(12'hf21, 8'h00);
		put(12'h0ff, 8'h11);
		put(12'h100, 8'h22);
		acc <= 8'hff;
		peek(12'hf02, 8'h11);
		peek(12'hf00, 8'h22);
		peek(12'hf01, 8'h22);
		peek(12'hf03, 8'h22);
		peek(12'hf04, 8'h11);
		peek(12'hf20, 8'h00);
		peek(12'hf21, 8'h01);
		put(12'hf02, 8'h33);
		peek(12'h100, 8'h33);
		peek(12'hf20, 8'h01);
		// pointer 1 wraps past the top of the data space
		put(12'hf22, 8'hff);
		put(12'hf23, 8'h0f);
		put(12'hfff, 8'h5a);
		peek(12'hf0a, 8'h5a);
		peek(12'hf22, 8'h00);
		peek(12'hf23, 8'h00);
		peek(12'hf0c, 8'h5a);
		// pointer 2 aimed at an operand port
		put(FLAGS_ADDR, 8'h00);
		put(12'hf24, 8'h00);
		put(12'hf25, 8'h0f);
		peek(12'hf10, 8'h00);
		chk("flags", 8'h04, alu_flags);
		put(FLAGS_ADDR, 8'hfb);
		peek(FLAGS_ADDR, 8'h1b);
		put(12'hf10, 8'h55);
		chk("flags", 8'h1b, alu_flags);
		put(12'h001, 8'h77);
		put(12'hf24, 8'h01);
		put(12'hf25, 8'h00);
		peek(12'hf11, 8'h77);
		peek(12'hf24, 8'h00);
		chk("flags", 8'h1b, alu_flags);
		// indirect write onto the pointer's own lower byte
		put(12'hf20, 8'h20);
		put(12'hf21, 8'h0f);
		put(12'hf02, 8'h40);
		peek(12'hf20, 8'h40);
		peek(12'hf21, 8'h0f);
		put(FLAGS_ADDR, 8'h00);
		for (int i = 0; i < 9; i++) begin
			core_model_i.alu(ops[i], va[i], vb[i], 1'b0);
			chk("result", vr[i], alu_result);
			chk("flags", vf[i], alu_flags);
		end
		core_model_i.alu(alu_add, 8'h01, 8'h01, 1'b1);
		chk("flags", 8'h00, alu_flags);
		tally_and_finish();
	end
endmodule : testbench
